//--- core/dram_cmd_core.sv
`timescale 1ns/1ns

// Functional notes
// - decode command from strobes at rising edge
// - deselect and no_op change nothing
// - long cal runs engine, loads impedance
// - short cal finishes within 64 cycles
// - activate opens row in selected bank
// - read start column, optional auto precharge
// - burst_chop_bit picks chop or eight
// - read burst always runs to end
// - write burst, optional auto precharge
// - byte_mask high leaves byte unchanged
// - precharge one or all, then wait
// - redundant precharge is no_op, restarts timing
// - refresh row is internal, one per command
module dram_cmd_core #(
  parameter int BANKS      = 8,
  parameter int BANK_BITS  = 3,
  parameter int ADDR_WIDTH = 14,
  parameter int ROW_BITS   = 2,
  parameter int COL_BITS   = 3,
  parameter int DATA_WIDTH = 8,
  parameter int IMP_WIDTH  = 6
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // command pins
  input  wire logic                  clock_gate_enable,
  input  wire logic                  select_n,
  input  wire logic                  row_strobe_n,
  input  wire logic                  column_strobe_n,
  input  wire logic                  write_strobe_n,
  input  wire logic [BANK_BITS-1:0]  bank_select,
  input  wire logic [ADDR_WIDTH-1:0] address,
  // data pins
  input  wire logic [DATA_WIDTH-1:0] write_data,
  input  wire logic                  byte_mask,
  output logic      [DATA_WIDTH-1:0] read_data,
  output logic                       read_valid,
  // calibration
  input  wire logic [IMP_WIDTH-1:0]  cal_target,
  output logic      [IMP_WIDTH-1:0]  driver_impedance,
  output logic      [IMP_WIDTH-1:0]  termination
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int PIN_W = 5 + BANK_BITS + ADDR_WIDTH + DATA_WIDTH + 1 + IMP_WIDTH;
  localparam int DEPTH = BANKS * (1 << ROW_BITS) * (1 << COL_BITS);
  localparam int IDX_W = BANK_BITS + ROW_BITS + COL_BITS;
  localparam int AP_BIT   = 10;
  localparam int CHOP_BIT = 12;
  localparam int ERR_WIDTH = dram_cmd_pkg::ERR_WIDTH;
  localparam int PRECHARGE_CYCLES_C = (dram_cmd_pkg::PRECHARGE_CYCLES < 1) ? 1
                                      : dram_cmd_pkg::PRECHARGE_CYCLES;

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  wire  [PIN_W-1:0] pin_raw = {clock_gate_enable, select_n, row_strobe_n, column_strobe_n,
                               write_strobe_n, bank_select, address, write_data, byte_mask,
                               cal_target};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire                  s_cke;
  wire                  s_cs_n;
  wire                  s_ras_n;
  wire                  s_cas_n;
  wire                  s_we_n;
  wire [BANK_BITS-1:0]  s_bank;
  wire [ADDR_WIDTH-1:0] s_addr;
  wire [DATA_WIDTH-1:0] s_wdata;
  wire                  s_mask;
  wire [IMP_WIDTH-1:0]  s_target;
  assign {s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_bank, s_addr, s_wdata, s_mask,
          s_target} = pin_sync;

  // ****************************************
  // command decode
  // ****************************************
  // cke low means no command is registered at all
  wire sel     = s_cke && !s_cs_n;
  wire cmd_act = sel && !s_ras_n && s_cas_n && s_we_n;
  wire cmd_rd  = sel && s_ras_n && !s_cas_n && s_we_n;
  wire cmd_wr  = sel && s_ras_n && !s_cas_n && !s_we_n;
  wire cmd_pre = sel && !s_ras_n && s_cas_n && !s_we_n;
  wire cmd_ref = sel && !s_ras_n && !s_cas_n && s_we_n;
  wire cmd_zq  = sel && s_ras_n && s_cas_n && !s_we_n;
  wire cmd_nop = !sel || (s_ras_n && s_cas_n && s_we_n);
  wire auto_pre = s_addr[AP_BIT];

  // ****************************************
  // control registers
  // ****************************************
  logic [1:0]           ctrl;
  logic [ERR_WIDTH-1:0] err;
  logic [15:0]          refresh_row;
  logic                 init_done;

  // ****************************************
  // per-bank row state
  // ****************************************
  logic [BANKS-1:0]    bank_open;
  logic [BANKS-1:0]    bank_pre_busy;
  logic [ROW_BITS-1:0] bank_row [BANKS];
  logic [7:0]          pre_cnt  [BANKS];

  logic                 burst_active;
  logic                 burst_write;
  logic                 burst_chop;
  logic                 burst_ap;
  logic [BANK_BITS-1:0] burst_bank;
  logic [COL_BITS-1:0]  burst_col;
  logic [2:0]           beat;
  logic [7:0]           ref_cnt;

  wire refreshing = (ref_cnt != 8'h00);
  wire burst_last = burst_active && (beat == (burst_chop ? 3'(dram_cmd_pkg::CHOP_BEATS - 1)
                                                         : 3'(dram_cmd_pkg::EIGHT_BEATS - 1)));
  wire all_idle   = (bank_open == '0) && (bank_pre_busy == '0);

  // commands are only acted on outside a refresh cycle
  wire take       = !refreshing;
  wire tgt_open   = bank_open[s_bank];
  wire ok_act     = take && cmd_act && !tgt_open && !bank_pre_busy[s_bank];
  wire ok_access  = take && (cmd_rd || cmd_wr) && tgt_open && !burst_active;
  wire ok_ref     = take && cmd_ref && all_idle;

  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      wire hit      = (s_bank == BANK_BITS'(b));
      // all-bank form ignores bank_select
      wire pre_cmd  = take && cmd_pre && (auto_pre || hit);
      // a redundant precharge still retimes the period from itself
      wire pre_go   = pre_cmd && (bank_open[b] || bank_pre_busy[b]);
      wire ap_go    = burst_last && burst_ap && (burst_bank == BANK_BITS'(b));

      assign bank_pre_busy[b] = (pre_cnt[b] != 8'h00);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bank_open[b] <= 1'b0;
          bank_row[b]  <= '0;
          pre_cnt[b]   <= 8'h00;
        end else if (pre_go || ap_go) begin
          bank_open[b] <= 1'b0;
          pre_cnt[b]   <= 8'(PRECHARGE_CYCLES_C);
        end else if (ok_act && hit) begin
          bank_open[b] <= 1'b1;
          bank_row[b]  <= s_addr[ROW_BITS-1:0];
        end else if (bank_pre_busy[b]) begin
          pre_cnt[b]   <= pre_cnt[b] - 8'h01;
        end
      end
    end
  endgenerate

  // ****************************************
  // burst engine
  // ****************************************
  // fixed length taken from ctrl unless on-the-fly selection is on
  wire chop_sel = ctrl[dram_cmd_pkg::CTRL_OTF_BIT] ? !s_addr[CHOP_BIT]
                                                   : ctrl[dram_cmd_pkg::CTRL_FIXED_CHOP_BIT];

  // sequential order; chop wraps inside its half of the column group
  wire [COL_BITS-1:0] col_eight = burst_col + COL_BITS'(beat);
  wire [COL_BITS-1:0] col_chop  = {burst_col[COL_BITS-1:2], burst_col[1:0] + beat[1:0]};
  wire [COL_BITS-1:0] beat_col  = burst_chop ? col_chop : col_eight;
  wire [IDX_W-1:0]    mem_idx   = {burst_bank, bank_row[burst_bank], beat_col};

  logic [DATA_WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_active <= 1'b0;
      burst_write  <= 1'b0;
      burst_chop   <= 1'b0;
      burst_ap     <= 1'b0;
      burst_bank   <= '0;
      burst_col    <= '0;
      beat         <= 3'h0;
    end else if (ok_access) begin
      burst_active <= 1'b1;
      burst_write  <= cmd_wr;
      burst_chop   <= chop_sel;
      burst_ap     <= auto_pre;
      burst_bank   <= s_bank;
      burst_col    <= s_addr[COL_BITS-1:0];
      beat         <= 3'h0;
    end else if (burst_last) begin
      burst_active <= 1'b0;
      beat         <= 3'h0;
    end else if (burst_active) begin
      beat         <= beat + 3'h1;
    end
  end

  // array storage has no reset: contents are undefined at power-up
  always_ff @(posedge pclk) begin
    if (burst_active && burst_write && !s_mask) begin
      mem[mem_idx] <= s_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_data  <= '0;
      read_valid <= 1'b0;
    end else begin
      read_valid <= burst_active && !burst_write;
      read_data  <= (burst_active && !burst_write) ? mem[mem_idx] : '0;
    end
  end

  // ****************************************
  // refresh
  // ****************************************
  localparam int REFRESH_CYCLES_C = (dram_cmd_pkg::REFRESH_CYCLES < 1) ? 1
                                    : dram_cmd_pkg::REFRESH_CYCLES;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt     <= 8'h00;
      refresh_row <= 16'h0000;
    end else if (ok_ref) begin
      ref_cnt     <= 8'(REFRESH_CYCLES_C);
      refresh_row <= refresh_row + 16'h0001;
    end else if (refreshing) begin
      ref_cnt     <= ref_cnt - 8'h01;
    end
  end

  // ****************************************
  // impedance calibration
  // ****************************************
  dram_cmd_pkg::cal_state_t cal_state;
  logic [9:0]               cal_cnt;
  logic [IMP_WIDTH-1:0]     cal_code;

  wire cal_start = take && cmd_zq && (cal_state == dram_cmd_pkg::cal_idle);
  wire [9:0] long_len = init_done ? 10'(dram_cmd_pkg::OPER_CAL_CYCLES)
                                  : 10'(dram_cmd_pkg::INIT_CAL_CYCLES);
  // step toward the reference, one code per cycle
  wire [IMP_WIDTH-1:0] next_code = (cal_code < s_target) ? cal_code + IMP_WIDTH'(1)
                                 : (cal_code > s_target) ? cal_code - IMP_WIDTH'(1)
                                 : cal_code;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_state        <= dram_cmd_pkg::cal_idle;
      cal_cnt          <= 10'h000;
      cal_code         <= '0;
      driver_impedance <= '0;
      termination      <= '0;
      init_done        <= 1'b0;
    end else begin
      case (cal_state)
        dram_cmd_pkg::cal_idle: begin
          if (cal_start) begin
            cal_cnt   <= s_addr[AP_BIT] ? long_len
                                        : 10'(dram_cmd_pkg::SHORT_CAL_CYCLES);
            cal_state <= s_addr[AP_BIT] ? dram_cmd_pkg::cal_long
                                        : dram_cmd_pkg::cal_short;
          end
        end
        dram_cmd_pkg::cal_long, dram_cmd_pkg::cal_short: begin
          cal_code <= next_code;
          cal_cnt  <= cal_cnt - 10'h001;
          if (cal_cnt == 10'h001) begin
            driver_impedance <= next_code;
            termination      <= next_code;
            if (cal_state == dram_cmd_pkg::cal_long) begin
              init_done <= 1'b1;
            end
            cal_state <= dram_cmd_pkg::cal_idle;
          end
        end
        default: begin
          cal_state <= dram_cmd_pkg::cal_idle;
        end
      endcase
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  wire hit_ctrl = (paddr == dram_cmd_pkg::CTRL_OFFSET);
  wire hit_stat = (paddr == dram_cmd_pkg::STATUS_OFFSET);
  wire hit_ref  = (paddr == dram_cmd_pkg::REFRESH_ROW_OFFSET);
  wire hit_imp  = (paddr == dram_cmd_pkg::IMPEDANCE_OFFSET);
  wire hit_err  = (paddr == dram_cmd_pkg::ERROR_OFFSET);
  wire mapped   = hit_ctrl || hit_stat || hit_ref || hit_imp || hit_err;
  wire wr_go    = psel && penable && pwrite && mapped;

  wire [31:0] status_word = {20'h00000, init_done, (cal_state != dram_cmd_pkg::cal_idle),
                             refreshing, burst_active, 8'(bank_open)};
  wire [31:0] imp_word    = {16'h0000, 8'(termination), 8'(driver_impedance)};
  wire [31:0] read_mux    = hit_ctrl ? {30'h00000000, ctrl}
                          : hit_stat ? status_word
                          : hit_ref  ? {16'h0000, refresh_row}
                          : hit_imp  ? imp_word
                          : hit_err  ? {28'h0000000, err}
                          : 32'h00000000;

  // error events: commands ignored during refresh, to a closed or open bank, or mid-burst leave a trace for software
  wire [ERR_WIDTH-1:0] err_set;
  assign err_set[dram_cmd_pkg::ERR_REFRESH_BIT] = refreshing && !cmd_nop;
  assign err_set[dram_cmd_pkg::ERR_CLOSED_BIT]  = take && (cmd_rd || cmd_wr) && !tgt_open;
  assign err_set[dram_cmd_pkg::ERR_OPEN_BIT]    = take && cmd_act && tgt_open;
  assign err_set[dram_cmd_pkg::ERR_BURST_BIT]   = take && (cmd_rd || cmd_wr) && burst_active;

  wire [ERR_WIDTH-1:0] err_clr = (wr_go && hit_err) ? pwdata[ERR_WIDTH-1:0] : '0;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= dram_cmd_pkg::CTRL_RESET;
      err    <= '0;
      prdata <= 32'h00000000;
    end else begin
      // set beats clear in the same cycle
      err <= (err & ~err_clr) | err_set;
      if (wr_go && hit_ctrl) begin
        ctrl <= pwdata[1:0];
      end
      if (psel && !penable) begin
        prdata <= read_mux;
      end
    end
  end

endmodule : dram_cmd_core

//--- core/dram_cmd_pkg.sv
package dram_cmd_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS        = 40;
  localparam int PRECHARGE_TIME_NS    = 15;
  localparam int PRECHARGE_CYCLES     = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYCLE_NS     = 160;
  localparam int REFRESH_CYCLES       = (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CAL_CYCLES      = 512;
  localparam int OPER_CAL_CYCLES      = 256;
  localparam int SHORT_CAL_CYCLES     = 64;
  localparam int CHOP_BEATS           = 4;
  localparam int EIGHT_BEATS          = 8;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CTRL_OFFSET        = 8'h00;
  localparam logic [7:0] STATUS_OFFSET      = 8'h04;
  localparam logic [7:0] REFRESH_ROW_OFFSET = 8'h08;
  localparam logic [7:0] IMPEDANCE_OFFSET   = 8'h0c;
  localparam logic [7:0] ERROR_OFFSET       = 8'h10;

  localparam int CTRL_OTF_BIT        = 0;
  localparam int CTRL_FIXED_CHOP_BIT = 1;
  localparam logic [1:0] CTRL_RESET  = 2'h1;

  localparam int STATUS_BURST_BIT    = 8;
  localparam int STATUS_REFRESH_BIT  = 9;
  localparam int STATUS_CAL_BIT      = 10;
  localparam int STATUS_INIT_BIT     = 11;

  localparam int ERR_REFRESH_BIT     = 0;
  localparam int ERR_CLOSED_BIT      = 1;
  localparam int ERR_OPEN_BIT        = 2;
  localparam int ERR_BURST_BIT       = 3;
  localparam int ERR_WIDTH           = 4;

  localparam int IMP_TERM_POS        = 8;

  // ****************************************
  // calibration states
  // ****************************************
  typedef enum logic [2:0] {
    cal_idle  = 3'b001,
    cal_long  = 3'b010,
    cal_short = 3'b100
  } cal_state_t;

endpackage : dram_cmd_pkg

//--- sim/dram_cmd_props.sv
`timescale 1ns/1ns

module dram_cmd_props #(
  parameter int ADDR_WIDTH = 14,
  parameter int IMP_WIDTH  = 6
) (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // command pins
  input wire logic                  clock_gate_enable,
  input wire logic                  select_n,
  input wire logic                  row_strobe_n,
  input wire logic                  column_strobe_n,
  input wire logic                  write_strobe_n,
  input wire logic [ADDR_WIDTH-1:0] address,
  // data and calibration
  input wire logic                  read_valid,
  input wire logic [IMP_WIDTH-1:0]  driver_impedance
);
  // ****************************************
  // pin decode
  // ****************************************
  localparam int CAL_BOUND = 600;
  wire logic live     = clock_gate_enable & ~select_n;
  wire logic pin_rd   = live & row_strobe_n & ~column_strobe_n & write_strobe_n;
  wire logic pin_zq   = live & row_strobe_n & column_strobe_n & ~write_strobe_n;
  wire logic chop_pin = address[12];
  wire logic mapped   = (paddr == dram_cmd_pkg::CTRL_OFFSET) |
                        (paddr == dram_cmd_pkg::STATUS_OFFSET) |
                        (paddr == dram_cmd_pkg::REFRESH_ROW_OFFSET) |
                        (paddr == dram_cmd_pkg::IMPEDANCE_OFFSET) |
                        (paddr == dram_cmd_pkg::ERROR_OFFSET);
  // ages saturate so an old command never looks fresh
  logic [9:0] zq_age;
  logic [7:0] rd_age;
  // burst length mode as software last wrote it
  logic [1:0] mode;
  wire logic  otf_on     = mode[dram_cmd_pkg::CTRL_OTF_BIT];
  wire logic  fixed_chop = mode[dram_cmd_pkg::CTRL_FIXED_CHOP_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zq_age <= 10'h3ff;
      rd_age <= 8'hff;
      mode   <= dram_cmd_pkg::CTRL_RESET;
    end else begin
      if (psel && penable && pready && pwrite && (paddr == dram_cmd_pkg::CTRL_OFFSET)) begin
        mode <= pwdata[1:0];
      end
      zq_age <= pin_zq ? 10'h000 : (zq_age == 10'h3ff ? zq_age : zq_age + 10'h001);
      rd_age <= pin_rd ? 8'h00 : (rd_age == 8'hff ? rd_age : rd_age + 8'h01);
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd_issued;
    $past(pin_rd, 4);
  endsequence
  // pin bit counts only with on-the-fly selection, mode seen at decode
  sequence s_start_chop;
    $rose(read_valid) ##0 ($past(otf_on, 2) ? !$past(chop_pin, 4) : $past(fixed_chop, 2));
  endsequence
  sequence s_start_eight;
    $rose(read_valid) ##0 ($past(otf_on, 2) ? $past(chop_pin, 4) : !$past(fixed_chop, 2));
  endsequence
  property p_ready;
    psel && penable |-> pready;
  endproperty
  property p_unmapped;
    psel && penable && !mapped |-> pslverr && (prdata == 32'h0);
  endproperty
  property p_mapped;
    psel && penable && mapped |-> !pslverr;
  endproperty
  property p_rd_latency;
    $rose(read_valid) |-> s_rd_issued;
  endproperty
  property p_chop;
    s_start_chop |-> read_valid [*4] ##1 !read_valid;
  endproperty
  property p_eight;
    s_start_eight |-> read_valid [*8] ##1 !read_valid;
  endproperty
  property p_rv_age;
    read_valid |-> rd_age <= 8'd10;
  endproperty
  property p_imp_cause;
    !$stable(driver_impedance) |-> zq_age < CAL_BOUND;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access phase");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  a_rd_latency: assert property (p_rd_latency)
    else $error("read data without read command four cycles earlier");
  a_chop: assert property (p_chop)
    else $error("chop burst not four beats");
  a_eight: assert property (p_eight)
    else $error("eight burst not eight beats");
  a_rv_age: assert property (p_rv_age)
    else $error("read data long after last read");
  a_imp_cause: assert property (p_imp_cause)
    else $error("impedance changed without calibration");
endmodule : dram_cmd_props

bind dram_cmd_core dram_cmd_props #(.ADDR_WIDTH(ADDR_WIDTH), .IMP_WIDTH(IMP_WIDTH)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_gate_enable(clock_gate_enable),
  .select_n(select_n), .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
  .write_strobe_n(write_strobe_n), .address(address), .read_valid(read_valid),
  .driver_impedance(driver_impedance));

//--- sim/dram_ctrl_model.sv
`timescale 1ns/1ns

module dram_ctrl_model (
  // clock
  input  wire logic   pclk,
  // command pins
  output logic        clock_gate_enable,
  output logic        select_n,
  output logic        row_strobe_n,
  output logic        column_strobe_n,
  output logic        write_strobe_n,
  output logic [2:0]  bank_select,
  output logic [13:0] address,
  // write beats
  output logic [7:0]  write_data,
  output logic        byte_mask
);
  initial begin
    clock_gate_enable = 1'b1;
    {select_n, row_strobe_n, column_strobe_n, write_strobe_n} = 4'hf;
    bank_select = 3'h0;
    address = 14'h0000;
    write_data = 8'h00;
    byte_mask = 1'b0;
  end
  // released address, data and mask lines flip so a stale value never passes for a live one; bank_select holds
  task automatic no_op();
    @(posedge pclk);
    {select_n, row_strobe_n, column_strobe_n, write_strobe_n} <= 4'h7;
    address <= ~address;
    write_data <= ~write_data;
    byte_mask <= ~byte_mask;
  endtask : no_op
  task automatic cmd(input logic [2:0] rcw, input logic [2:0] bank, input logic [13:0] addr);
    @(posedge pclk);
    {select_n, row_strobe_n, column_strobe_n, write_strobe_n} <= {1'b0, rcw};
    bank_select <= bank;
    address <= addr;
  endtask : cmd
  task automatic wr_burst(input logic [2:0] bank, input logic [13:0] addr,
                          input logic [7:0] base, input int skip);
    cmd(3'h4, bank, addr);
    for (int k = 0; k < 8; k++) begin
      @(posedge pclk);
      {select_n, row_strobe_n, column_strobe_n, write_strobe_n} <= 4'h7;
      address <= ~address;
      write_data <= base + 8'(k);
      byte_mask <= (k == skip);
    end
    repeat (4) no_op();
  endtask : wr_burst
  task automatic refresh();
    cmd(3'h1, 3'h0, 14'h0000);
    repeat (dram_cmd_pkg::REFRESH_CYCLES + 2) no_op();
  endtask : refresh
endmodule : dram_ctrl_model

//--- sim/sdram_command_bank_refresh_bench.sv
`timescale 1ns/1ns
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end

module sdram_command_bank_refresh_bench;
  // ****************************************
  // signals
  // ****************************************
  localparam logic [7:0] ST = dram_cmd_pkg::STATUS_OFFSET;
  localparam logic [7:0] ER = dram_cmd_pkg::ERROR_OFFSET;
  localparam logic [7:0] RR = dram_cmd_pkg::REFRESH_ROW_OFFSET;
  localparam logic [63:0] FULL = 64'h87868584_43828180;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        clock_gate_enable, select_n, row_strobe_n, column_strobe_n, write_strobe_n;
  logic        byte_mask, read_valid;
  logic [2:0]  bank_select;
  logic [7:0]  paddr, read_data, write_data;
  logic [13:0] address;
  logic [5:0]  cal_target, driver_impedance, termination;
  logic [31:0] pwdata, prdata, q, row0;
  int          n_mismatch, n_compared, cycles;

  dram_cmd_core u_dram_cmd_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clock_gate_enable(clock_gate_enable),
    .select_n(select_n), .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_strobe_n(write_strobe_n), .bank_select(bank_select), .address(address),
    .write_data(write_data), .byte_mask(byte_mask), .read_data(read_data),
    .read_valid(read_valid), .cal_target(cal_target), .driver_impedance(driver_impedance),
    .termination(termination));
  dram_ctrl_model u_ctrl (.pclk(pclk), .clock_gate_enable(clock_gate_enable),
    .select_n(select_n), .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_strobe_n(write_strobe_n), .bank_select(bank_select), .address(address),
    .write_data(write_data), .byte_mask(byte_mask));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // whole run needs about 850 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHECK(q, e)
  endtask : rd
  task automatic op(input logic [2:0] rcw, input logic [2:0] bank, input logic [13:0] addr);
    u_ctrl.cmd(rcw, bank, addr);
    repeat (3) u_ctrl.no_op();
  endtask : op
  task automatic rd_burst(input logic [2:0] bank, input logic [13:0] addr,
                          input logic [63:0] e, input int n, input logic again);
    u_ctrl.cmd(3'h5, bank, addr);
    u_ctrl.no_op();
    if (again) begin
      u_ctrl.no_op();
      u_ctrl.cmd(3'h5, bank, addr);
      u_ctrl.no_op();
    end
    for (int i = 0; i < 20 && read_valid !== 1'b1; i++) @(negedge pclk);
    for (int k = 0; k < n; k++) begin
      `CHECK(read_data, e[8*k +: 8])
      @(negedge pclk);
    end
    repeat (4) u_ctrl.no_op();
  endtask : rd_burst

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    cal_target = 6'h15;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(dram_cmd_pkg::CTRL_OFFSET, 32'h1);
    rd(ST, 32'h0);
    apb(1'b1, 8'h14, 32'hffffffff);
    `CHECK(err, 1'b1)
    rd(8'h14, 32'h0);
    u_ctrl.cmd(3'h6, 3'h0, 14'h0400);
    repeat (dram_cmd_pkg::INIT_CAL_CYCLES + 8) u_ctrl.no_op();
    `CHECK(driver_impedance, 6'h15)
    `CHECK(termination, 6'h15)
    rd(ST, 32'h800);
    cal_target <= 6'h16;
    u_ctrl.cmd(3'h6, 3'h0, 14'h0000);
    repeat (dram_cmd_pkg::SHORT_CAL_CYCLES + 4) u_ctrl.no_op();
    `CHECK(driver_impedance, 6'h16)
    rd(dram_cmd_pkg::IMPEDANCE_OFFSET, 32'h1616);
    op(3'h3, 3'h2, 14'h0001);
    rd(ST, 32'h804);
    u_ctrl.wr_burst(3'h2, 14'h1000, 8'h40, 8);
    u_ctrl.wr_burst(3'h2, 14'h1000, 8'h80, 3);
    rd_burst(3'h2, 14'h1000, FULL, 8, 1'b0);
    rd_burst(3'h2, 14'h0005, 64'h0_84878685, 4, 1'b1);
    rd(ER, 32'h8);
    apb(1'b1, ER, 32'hf);
    rd(ER, 32'h0);
    apb(1'b1, dram_cmd_pkg::CTRL_OFFSET, 32'h2);
    rd(dram_cmd_pkg::CTRL_OFFSET, 32'h2);
    rd_burst(3'h2, 14'h1004, 64'h0_87868584, 4, 1'b0);
    apb(1'b1, dram_cmd_pkg::CTRL_OFFSET, 32'h1);
    rd_burst(3'h2, 14'h1400, FULL, 8, 1'b0);
    rd(ST, 32'h800);
    rd_burst(3'h2, 14'h1000, FULL, 0, 1'b0);
    `CHECK(read_valid, 1'b0)
    op(3'h3, 3'h1, 14'h0002);
    op(3'h3, 3'h4, 14'h0003);
    op(3'h3, 3'h1, 14'h0001);
    rd(ST, 32'h812);
    op(3'h2, 3'h1, 14'h0000);
    rd(ST, 32'h810);
    op(3'h2, 3'h1, 14'h0000);
    op(3'h2, 3'h1, 14'h0400);
    rd(ST, 32'h800);
    rd(ER, 32'h6);
    apb(1'b1, ER, 32'hf);
    rd(RR, 32'h0);
    row0 = q;
    u_ctrl.cmd(3'h1, 3'h5, 14'h3fff);
    op(3'h3, 3'h3, 14'h0001);
    repeat (4) u_ctrl.no_op();
    rd(ST, 32'h800);
    rd(ER, 32'h1);
    rd(RR, row0 + 32'h1);
    u_ctrl.refresh();
    rd(RR, row0 + 32'h2);
    report_and_stop();
  end
endmodule : sdram_command_bank_refresh_bench
